//--- sfc_pkg.sv
// sample fifo control: register map, field layout, reset values and sizes
package sfc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SFC_CTRL_ADDR = 8'h2D;
  localparam logic [7:0] SFC_TH_ADDR = 8'h2E;
  localparam logic [7:0] SFC_STAT_ADDR = 8'h2F;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SFC_PTR_RESET_BIT = 4;
  localparam int SFC_STAT_EMPTY_BIT = 0;
  localparam int SFC_STAT_FULL_BIT = 1;
  localparam int SFC_STAT_TH_BIT = 2;
  localparam int SFC_TH_W = 5;
  localparam logic [7:0] SFC_CTRL_RST = 8'h00;
  localparam logic [SFC_TH_W-1:0] SFC_TH_RST = 5'h10;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SFC_STORE_DEPTH = 32;
  localparam int SFC_STAGE_DEPTH = 4;
  localparam int SFC_SAMPLE_W = 48;

  // control register layout, bit 7 first
  typedef struct packed {
    logic reserved;
    logic watermark_mode;
    logic fifo_enable;
    logic fifo_pointer_reset;
    logic combine_interrupts;
    logic threshold_irq_enable;
    logic full_irq_enable;
    logic empty_irq_enable;
  } sfc_ctrl_s;

endpackage

//--- sfc_sample_fifo.sv
// sample fifo control: 32-entry sample store, drain staging buffer, registers
`timescale 1ns/10ps

// ------------------------------------------------------------------
// staging buffer between the sample store and the reader
// ------------------------------------------------------------------
module sfc_stage_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != FULL_CNT) && !flush_i;
  assign out_valid_o = (count != '0) && !flush_i;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rptr];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || flush_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == LAST_PTR) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == LAST_PTR) ? '0 : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sfc_stage_fifo

// ------------------------------------------------------------------
// sample fifo control top
// ------------------------------------------------------------------
module sfc_sample_fifo
  import sfc_pkg::*;
#(
  parameter int SAMPLE_W = SFC_SAMPLE_W,
  parameter int DEPTH = SFC_STORE_DEPTH,
  parameter int STAGE_DEPTH = SFC_STAGE_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire logic [SAMPLE_W-1:0] sample_data_i,
  output logic sample_ready_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [SAMPLE_W-1:0] rd_data_o,
  input wire logic motion_irq_i,
  input wire logic sample_irq_i,
  output logic irq_out_primary_n_o,
  output logic irq_out_secondary_n_o,
  output logic fifo_irq_pending_o,
  output logic [$clog2(DEPTH+1)-1:0] fifo_count_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  sfc_ctrl_s ctrl;
  logic [SFC_TH_W-1:0] threshold_level;
  logic [SAMPLE_W-1:0] store [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] count;
  logic do_reset;
  logic at_threshold;
  logic push;
  logic pop;
  logic stage_ready;
  logic [2:0] status;
  logic fifo_any;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // pointer reset strobe
  assign do_reset = reg_wr_i && (reg_addr_i == SFC_CTRL_ADDR)
                    && reg_wdata_i[SFC_PTR_RESET_BIT];

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctrl <= sfc_ctrl_s'(SFC_CTRL_RST);
    end else if (reg_wr_i && reg_addr_i == SFC_CTRL_ADDR) begin
      ctrl <= sfc_ctrl_s'(reg_wdata_i);
      ctrl.fifo_pointer_reset <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      threshold_level <= SFC_TH_RST;
    end else if (reg_wr_i && reg_addr_i == SFC_TH_ADDR) begin
      threshold_level <= reg_wdata_i[SFC_TH_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // sample store
  // ----------------------------------------------------------------
  // threshold condition from count
  assign at_threshold = count >= {1'b0, threshold_level};
  // accept only when enabled, not full
  // and, in watermark mode, below the threshold
  assign sample_ready_o = ctrl.fifo_enable && (count != FULL_CNT)
                          && !(ctrl.watermark_mode && at_threshold)
                          && !do_reset;
  assign push = sample_valid_i && sample_ready_o;
  assign pop = ctrl.fifo_enable && (count != '0) && stage_ready && !do_reset;

  // contents survive a pointer reset, so no reset here
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      store[wptr] <= sample_data_i;
    end
  end

  // pointers and count cleared, store untouched
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || do_reset) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == LAST_PTR) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == LAST_PTR) ? '0 : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  assign fifo_count_o = count;

  // staging buffer decouples the reader's stalls from the store
  sfc_stage_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .flush_i(do_reset),
    .in_valid_i(pop),
    .in_ready_o(stage_ready),
    .in_data_i(store[rptr]),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i && ctrl.fifo_enable),
    .out_data_o(rd_data_o)
  );

  // ----------------------------------------------------------------
  // status and interrupt routing
  // ----------------------------------------------------------------
  // enable-gated flags
  assign status[SFC_STAT_EMPTY_BIT] = ctrl.empty_irq_enable && (count == '0);
  assign status[SFC_STAT_FULL_BIT] = ctrl.full_irq_enable
                                     && (count == FULL_CNT);
  assign status[SFC_STAT_TH_BIT] = ctrl.threshold_irq_enable && at_threshold;
  assign fifo_any = |status;

  // routing; outputs registered to stay glitch free
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_out_primary_n_o <= 1'b1;
      irq_out_secondary_n_o <= 1'b1;
      fifo_irq_pending_o <= 1'b0;
    end else begin
      irq_out_primary_n_o <= !(motion_irq_i || sample_irq_i
                               || (ctrl.combine_interrupts && fifo_any));
      irq_out_secondary_n_o <= !(!ctrl.combine_interrupts && fifo_any);
      fifo_irq_pending_o <= fifo_any;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      SFC_CTRL_ADDR: next_rdata = ctrl;
      SFC_TH_ADDR: next_rdata = {3'h0, threshold_level};
      SFC_STAT_ADDR: next_rdata = {5'h00, status};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  empty_flag_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      reg_rd_i && reg_addr_i == SFC_STAT_ADDR |=>
      reg_rdata_o[0] == $past(ctrl.empty_irq_enable && count == '0))
    else $error("empty flag wrong");
  full_flag_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      reg_rd_i && reg_addr_i == SFC_STAT_ADDR |=>
      reg_rdata_o[1] == $past(ctrl.full_irq_enable && count == FULL_CNT))
    else $error("full flag wrong");
  th_flag_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      reg_rd_i && reg_addr_i == SFC_STAT_ADDR |=> reg_rdata_o[2] ==
      $past(ctrl.threshold_irq_enable && count >= {1'b0, threshold_level}))
    else $error("threshold flag wrong");
  irq_route_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ctrl.combine_interrupts |=> irq_out_secondary_n_o)
    else $error("secondary not disabled when combined");
  ptr_clear_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      do_reset |=> count == '0 && !rd_valid_o)
    else $error("pointer reset left data");
  disabled_hold_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !ctrl.fifo_enable && !do_reset |=> $stable(count))
    else $error("count moved while disabled");
  normal_store_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      sample_valid_i && ctrl.fifo_enable && !ctrl.watermark_mode
      && count != FULL_CNT && !do_reset && !pop
      |=> count == $past(count) + 1'b1)
    else $error("sample not stored in normal mode");
  mark_drop_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ctrl.watermark_mode && at_threshold && !do_reset
      |-> !sample_ready_o ##1 count <= $past(count))
    else $error("sample taken above watermark");
  th_write_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      reg_wr_i && reg_addr_i == SFC_TH_ADDR
      |=> threshold_level == $past(reg_wdata_i[4:0]))
    else $error("threshold write lost");
  th_powerup_a:
    assert property (@(posedge ref_clk_i)
      $rose(nrst_i) |-> threshold_level == SFC_TH_RST)
    else $error("threshold reset value wrong");
  th_reserved_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      reg_rd_i && reg_addr_i == SFC_TH_ADDR |=> reg_rdata_o[7:5] == 3'h0)
    else $error("reserved threshold bits set");
  pend_sum_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ##1 fifo_irq_pending_o == $past(|status))
    else $error("summary pending wrong");
  full_block_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      count == FULL_CNT |-> !sample_ready_o)
    else $error("sample taken while full");
  oneshot_a:
    assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      do_reset |=> !ctrl.fifo_pointer_reset)
    else $error("pointer reset bit stuck");
endmodule // sfc_sample_fifo

//--- sfc_host_model.sv
// host-side reader model that drains the sample staging buffer
`timescale 1ns/10ps

module sfc_host_model
  import sfc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic rd_valid_i,
  input wire logic [SFC_SAMPLE_W-1:0] rd_data_i,
  output logic rd_ready_o,
  output int taken_o,
  output logic [SFC_SAMPLE_W-1:0] last_o
);
  // a stalled host lets the store build up, which is how full and watermark
  // conditions are reached at all
  assign rd_ready_o = !stall_i;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      taken_o <= 0;
      last_o <= '0;
    end else if (rd_valid_i && rd_ready_o) begin
      taken_o <= taken_o + 1;
      last_o <= rd_data_i;
    end
  end
endmodule // sfc_host_model

//--- testbench.sv
// self-checking bench for the sample fifo control block
`timescale 1ns/10ps

module testbench
  import sfc_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, s_valid = 1'b0, mot = 1'b0, smp = 1'b0;
  logic stall = 1'b1;
  logic [SFC_SAMPLE_W-1:0] s_data = '0;
  logic [7:0] rdata;
  logic s_ready, r_valid, r_ready, irq_p_n, irq_s_n, pend;
  logic [SFC_SAMPLE_W-1:0] r_data, last;
  logic [5:0] count;
  int taken, n_errors = 0, n_compared = 0, cycles = 0;
  logic [7:0] rows [8][3] = '{'{8'h2D, 8'h07, 8'h07}, '{8'h2F, 8'hFF, 8'h01},
    '{8'h2E, 8'hE1, 8'h01}, '{8'h2F, 8'h00, 8'h01}, '{8'h2E, 8'hFF, 8'h1F},
    '{8'h2D, 8'h10, 8'h00}, '{8'h30, 8'hAA, 8'h00}, '{8'h2D, 8'h08, 8'h08}};
  // ctrl, motion, sample, primary_n, secondary_n
  logic [7:0] irows [6][5] = '{'{8'h01, 0, 0, 1, 0}, '{8'h01, 1, 0, 0, 0},
    '{8'h09, 1, 0, 0, 1}, '{8'h09, 0, 0, 0, 1}, '{8'h08, 0, 0, 1, 1},
    '{8'h00, 0, 1, 0, 1}};

  sfc_sample_fifo sfc_sample_fifo_inst (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_valid_i(s_valid),
    .sample_data_i(s_data), .sample_ready_o(s_ready), .rd_valid_o(r_valid),
    .rd_ready_i(r_ready), .rd_data_o(r_data), .motion_irq_i(mot),
    .sample_irq_i(smp), .irq_out_primary_n_o(irq_p_n),
    .irq_out_secondary_n_o(irq_s_n), .fifo_irq_pending_o(pend),
    .fifo_count_o(count));

  sfc_host_model sfc_host_model_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .stall_i(stall), .rd_valid_i(r_valid), .rd_data_i(r_data),
    .rd_ready_o(r_ready), .taken_o(taken), .last_o(last));

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 chk(48'(rdata), 48'(exp));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // samples go in one per cycle; refused ones are simply lost
  task automatic push(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      s_valid <= 1'b1;
      s_data <= 48'(base + i);
    end
    @(posedge ref_clk_i);
    s_valid <= 1'b0;
  endtask

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_reg(SFC_CTRL_ADDR, 8'h00);
    rd_reg(SFC_TH_ADDR, 8'h10);
    chk(48'({irq_p_n, irq_s_n, pend}), 48'h6);
    for (int i = 0; i < 8; i++) begin
      wr_reg(rows[i][0], rows[i][1]);
      rd_reg(rows[i][0], rows[i][2]);
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(SFC_CTRL_ADDR, irows[i][0]);
      mot <= irows[i][1][0];
      smp <= irows[i][2][0];
      idle(3);
      chk(48'({irq_p_n, irq_s_n}), 48'(irows[i][3]*2 + irows[i][4]));
    end
    smp <= 1'b0;
    // watermark mode with the host stalled: 4 staged plus 2 stored
    wr_reg(SFC_TH_ADDR, 8'h02);
    for (int k = 0; k < 2; k++) begin
      wr_reg(SFC_CTRL_ADDR, 8'h64);
      push(10, 0);
      idle(4);
      chk(48'(count), 48'd2);
      chk(48'(s_ready), 48'd0);
      rd_reg(SFC_STAT_ADDR, 8'h04);
      chk(48'(pend), 48'd1);
      wr_reg(SFC_CTRL_ADDR, 8'h74);
      #1 chk(48'({count, r_valid}), 48'd0);
      rd_reg(SFC_CTRL_ADDR, 8'h64);
    end
    wr_reg(SFC_CTRL_ADDR, 8'h00);
    push(3, 0);
    idle(3);
    chk(48'({count, s_ready, r_valid}), 48'd0);
    // normal mode fills to capacity, then the host drains everything
    wr_reg(SFC_CTRL_ADDR, 8'h22);
    push(40, 100);
    idle(4);
    chk(48'(count), 48'd32);
    rd_reg(SFC_STAT_ADDR, 8'h02);
    chk(48'({s_ready, pend}), 48'd1);
    stall <= 1'b0;
    idle(60);
    chk(48'(count), 48'd0);
    chk(48'(taken), 48'd36);
    chk(last, 48'd135);
    rd_reg(SFC_STAT_ADDR, 8'h00);
    wr_reg(SFC_CTRL_ADDR, 8'h23);
    rd_reg(SFC_STAT_ADDR, 8'h01);
    // mid-run reset: secondary is asserted and threshold is 2 beforehand
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_reg(SFC_CTRL_ADDR, 8'h00);
    rd_reg(SFC_TH_ADDR, 8'h10);
    chk(48'({irq_p_n, irq_s_n, pend, s_ready}), 48'hC);
    complete_run();
  end
endmodule // testbench
